// ### design/shrw_pkg.sv
// constants and types shared by the sensor host register window
package shrw_pkg;
  // host-visible register offsets
  localparam logic [7:0] AUX_RESULT_HIGH_OFS = 8'h2d;
  localparam logic [7:0] PARAM_READBACK_OFS = 8'h2e;
  localparam logic [7:0] POWER_STATE_FLAGS_OFS = 8'h30;
  localparam logic [7:0] ANALOG_KEY_OFS = 8'h3b;
  localparam int ANALOG_KEY_BYTES = 4;

  // reset values of host-visible registers
  localparam logic [7:0] AUX_RESULT_HIGH_RST = 8'h00;
  localparam logic [7:0] PARAM_READBACK_RST = 8'h00;
  localparam logic [7:0] ANALOG_KEY_RST = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // power-state flag positions; bits 7:3 read zero
  localparam int AWAKE_FLAG_BIT = 2;
  localparam int SUSPEND_FLAG_BIT = 1;
  localparam int SLEEP_FLAG_BIT = 0;

  // parameter memory geometry and notable offsets
  localparam int PARAM_DEPTH = 32;
  localparam int PARAM_AW = 5;
  localparam logic [PARAM_AW-1:0] BUS_ADDRESS_PARAM = 5'h00;
  localparam logic [PARAM_AW-1:0] CHANNEL_ENABLE_LIST_PARAM = 5'h01;
  localparam logic [PARAM_AW-1:0] PROX_ADC_COUNTER_PARAM = 5'h0a;
  localparam logic [PARAM_AW-1:0] RSVD_0D_PARAM = 5'h0d;
  localparam logic [PARAM_AW-1:0] RSVD_13_PARAM = 5'h13;
  localparam logic [PARAM_AW-1:0] RSVD_14_PARAM = 5'h14;
  localparam logic [PARAM_AW-1:0] RSVD_15_PARAM = 5'h15;

  // parameter reset values
  localparam logic [7:0] PARAM_DEFAULT_RST = 8'h00;
  localparam logic [7:0] RSVD_0D_RST = 8'h02;
  localparam logic [7:0] RSVD_13_RST = 8'h40;
  localparam logic [7:0] RSVD_14_RST = 8'h00;
  localparam logic [7:0] RSVD_15_RST = 8'h00;

  // low reserved field of the proximity converter counter
  localparam logic [7:0] PROX_ADC_COUNTER_RSVD_MASK = 8'h0f;

  // commands from the command engine
  typedef enum logic [1:0] {
    SHRW_CMD_NONE,
    SHRW_CMD_FETCH,
    SHRW_CMD_STORE,
    SHRW_CMD_APPLY_ADDR
  } shrw_cmd_t;

  typedef enum {
    SHRW_PWR_AWAKE,
    SHRW_PWR_SUSPEND,
    SHRW_PWR_SLEEP
  } shrw_pwr_t;

  // reset value of every parameter entry
  function automatic logic [7:0] shrw_param_default(input logic [PARAM_AW-1:0] ofs);
    case (ofs)
      RSVD_0D_PARAM: shrw_param_default = RSVD_0D_RST;
      RSVD_13_PARAM: shrw_param_default = RSVD_13_RST;
      RSVD_14_PARAM: shrw_param_default = RSVD_14_RST;
      RSVD_15_PARAM: shrw_param_default = RSVD_15_RST;
      default: shrw_param_default = PARAM_DEFAULT_RST;
    endcase
  endfunction : shrw_param_default
endpackage : shrw_pkg

// ### design/shrw_ram_if.sv
// carrier between the register window and its parameter memory
`timescale 1ns/1ps
`default_nettype none
interface shrw_ram_if;
  import shrw_pkg::*;
  logic we;
  logic [PARAM_AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] bus_address;

  modport ctrl (output we, output addr, output wdata, input rdata, input bus_address);
  modport mem (input we, input addr, input wdata, output rdata, output bus_address);
endinterface : shrw_ram_if
`default_nettype wire

// ### design/shrw_param_ram.sv
// indirect parameter memory with per-entry reset defaults
`timescale 1ns/1ps
`default_nettype none
module shrw_param_ram (
  input wire logic clock,
  input wire logic reset_n,
  shrw_ram_if.mem ram
);
  import shrw_pkg::*;

  logic [7:0] mem [PARAM_DEPTH];
  logic [7:0] next_mem [PARAM_DEPTH];

  // not on the host register map; only the command path reaches it
  always_comb begin
    for (int i = 0; i < PARAM_DEPTH; i++) begin
      next_mem[i] = mem[i];
    end
    if (ram.we) begin
      next_mem[ram.addr] = ram.wdata;
    end
  end

  always_ff @(posedge clock) begin
    for (int i = 0; i < PARAM_DEPTH; i++) begin
      if (!reset_n) begin
        mem[i] <= shrw_param_default(PARAM_AW'(i));
      end else begin
        mem[i] <= next_mem[i];
      end
    end
  end

  assign ram.rdata = mem[ram.addr];
  assign ram.bus_address = mem[BUS_ADDRESS_PARAM];

  a_ram_store_lands: assert property (@(posedge clock) disable iff (!reset_n)
    ram.we |=> mem[$past(ram.addr)] == $past(ram.wdata))
    else $error("parameter store did not land");
endmodule : shrw_param_ram
`default_nettype wire

// ### design/shrw_register_window.sv
// host register slice: aux high byte, mailbox, power flags, key area
// What this block does
// - 8-bit mailbox to host, resets zero
// - bit2 awake, bit1 suspended awaiting measurement
// - bit0 deepest sleep; bits 7:3 reserved
// - parameters live in unmapped internal memory
// - new bus address active on apply command
`timescale 1ns/1ps
`default_nettype none
module shrw_register_window #(
  parameter logic [7:0] ACTIVE_ADDRESS_RST = 8'h00
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic cmd_valid,
  input wire shrw_pkg::shrw_cmd_t cmd_code,
  input wire logic [shrw_pkg::PARAM_AW-1:0] cmd_offset,
  input wire logic [7:0] cmd_data,
  input wire logic aux_load,
  input wire logic [7:0] aux_value,
  input wire logic seq_wake,
  input wire logic seq_suspend,
  input wire logic seq_sleep,
  output logic [7:0] active_bus_address,
  output logic channel_list_ready,
  output logic [7:0] power_state
);
  import shrw_pkg::*;

  shrw_ram_if ram_if ();

  shrw_param_ram u_param_ram (
    .clock(clock),
    .reset_n(reset_n),
    .ram(ram_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] aux_result_high;
  logic [7:0] param_readback;
  logic [7:0] analog_key_reserved [ANALOG_KEY_BYTES];
  logic [7:0] channel_enable_list;
  shrw_pwr_t pwr;
  logic [7:0] next_reg_rdata;
  logic next_reg_rvalid;
  logic [7:0] next_aux_result_high;
  logic [7:0] next_param_readback;
  logic [7:0] next_analog_key_reserved [ANALOG_KEY_BYTES];
  logic [7:0] next_active_bus_address;
  logic [7:0] next_channel_enable_list;
  shrw_pwr_t next_pwr;
  logic [7:0] pwr_flags;
  logic is_fetch;
  logic is_store;
  logic is_apply;

  assign is_fetch = cmd_valid && (cmd_code == SHRW_CMD_FETCH);
  assign is_store = cmd_valid && (cmd_code == SHRW_CMD_STORE);
  assign is_apply = cmd_valid && (cmd_code == SHRW_CMD_APPLY_ADDR);

  function automatic logic key_hit(input logic [7:0] a);
    key_hit = (a >= ANALOG_KEY_OFS) && (a < ANALOG_KEY_OFS + 8'(ANALOG_KEY_BYTES));
  endfunction : key_hit

  ////////////////////////////////////////////////////////////////////////////
  // parameter memory access, only from the command engine

  always_comb begin
    ram_if.addr = cmd_offset;
    ram_if.we = is_store;
    ram_if.wdata = cmd_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // power state tracking; wake outranks suspend, suspend outranks sleep

  always_comb begin
    next_pwr = pwr;
    if (seq_wake) begin
      next_pwr = SHRW_PWR_AWAKE;
    end else if (seq_suspend) begin
      next_pwr = SHRW_PWR_SUSPEND;
    end else if (seq_sleep) begin
      next_pwr = SHRW_PWR_SLEEP;
    end
  end

  always_comb begin
    pwr_flags = 8'h00;
    case (pwr)
      SHRW_PWR_AWAKE: pwr_flags[AWAKE_FLAG_BIT] = 1'b1;
      SHRW_PWR_SUSPEND: pwr_flags[SUSPEND_FLAG_BIT] = 1'b1;
      SHRW_PWR_SLEEP: pwr_flags[SLEEP_FLAG_BIT] = 1'b1;
      default: pwr_flags = 8'h00;
    endcase
  end

  assign power_state = pwr_flags;

  ////////////////////////////////////////////////////////////////////////////
  // register writes and sequencer updates

  always_comb begin
    next_aux_result_high = aux_result_high;
    next_param_readback = param_readback;
    next_active_bus_address = active_bus_address;
    next_channel_enable_list = channel_enable_list;
    for (int i = 0; i < ANALOG_KEY_BYTES; i++) begin
      next_analog_key_reserved[i] = analog_key_reserved[i];
    end
    if (reg_wr) begin
      if (reg_addr == AUX_RESULT_HIGH_OFS) begin
        next_aux_result_high = reg_wdata;
      end
      if (reg_addr == PARAM_READBACK_OFS) begin
        next_param_readback = reg_wdata;
      end
      if (key_hit(reg_addr)) begin
        next_analog_key_reserved[2'(reg_addr - ANALOG_KEY_OFS)] = reg_wdata;
      end
      // power flags have no write path at all
    end
    // a fresh measurement overwrites the last one; the host must be done by then
    if (aux_load) begin
      next_aux_result_high = aux_value;
    end
    // sequencer hand-off beats a same-cycle host write, and the host's value is dropped
    if (is_fetch) begin
      next_param_readback = ram_if.rdata;
    end else if (is_store) begin
      next_param_readback = cmd_data;
    end
    // address parameter only takes effect here
    if (is_apply) begin
      next_active_bus_address = ram_if.bus_address;
    end
    if (is_store && (cmd_offset == CHANNEL_ENABLE_LIST_PARAM)) begin
      next_channel_enable_list = cmd_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads, answered one cycle after the strobe

  always_comb begin
    next_reg_rvalid = reg_rd;
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      next_reg_rdata = UNMAPPED_READ;
      if (reg_addr == AUX_RESULT_HIGH_OFS) begin
        next_reg_rdata = aux_result_high;
      end else if (reg_addr == PARAM_READBACK_OFS) begin
        next_reg_rdata = param_readback;
      end else if (reg_addr == POWER_STATE_FLAGS_OFS) begin
        next_reg_rdata = pwr_flags;
      end else if (key_hit(reg_addr)) begin
        next_reg_rdata = analog_key_reserved[2'(reg_addr - ANALOG_KEY_OFS)];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      aux_result_high <= AUX_RESULT_HIGH_RST;
      param_readback <= PARAM_READBACK_RST;
      active_bus_address <= ACTIVE_ADDRESS_RST;
      channel_enable_list <= PARAM_DEFAULT_RST;
      pwr <= SHRW_PWR_AWAKE;
      reg_rdata <= UNMAPPED_READ;
      reg_rvalid <= 1'b0;
      for (int i = 0; i < ANALOG_KEY_BYTES; i++) begin
        analog_key_reserved[i] <= ANALOG_KEY_RST;
      end
    end else begin
      aux_result_high <= next_aux_result_high;
      param_readback <= next_param_readback;
      active_bus_address <= next_active_bus_address;
      channel_enable_list <= next_channel_enable_list;
      pwr <= next_pwr;
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
      for (int i = 0; i < ANALOG_KEY_BYTES; i++) begin
        analog_key_reserved[i] <= next_analog_key_reserved[i];
      end
    end
  end

  // advisory only: measuring with an empty list is the host's fault
  assign channel_list_ready = (channel_enable_list != 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_mailbox_fetch: assert property (@(posedge clock) disable iff (!reset_n)
    is_fetch |=> param_readback == $past(ram_if.rdata))
    else $error("mailbox missed fetched parameter");

  a_mailbox_reset: assert property (@(posedge clock)
    !reset_n |=> param_readback == 8'h00)
    else $error("mailbox not zero after reset");

  a_flags_onehot: assert property (@(posedge clock) disable iff (!reset_n)
    $onehot(power_state[2:0]) && power_state[7:3] == 5'h00)
    else $error("power flags not one-hot");

  a_wake_sets_flag: assert property (@(posedge clock) disable iff (!reset_n)
    seq_wake |=> power_state == 8'h04)
    else $error("wake did not set awake flag");

  a_sleep_sets_flag: assert property (@(posedge clock) disable iff (!reset_n)
    seq_sleep && !seq_wake && !seq_suspend |=> power_state == 8'h01)
    else $error("sleep did not set sleep flag");

  a_address_holds: assert property (@(posedge clock) disable iff (!reset_n)
    !is_apply |=> $stable(active_bus_address))
    else $error("bus address changed without apply");

  a_address_apply: assert property (@(posedge clock) disable iff (!reset_n)
    is_apply |=> active_bus_address == $past(ram_if.bus_address))
    else $error("apply did not load bus address");

  a_flags_write_ignored: assert property (@(posedge clock) disable iff (!reset_n)
    reg_wr && reg_addr == POWER_STATE_FLAGS_OFS && !seq_wake && !seq_suspend && !seq_sleep
    |=> $stable(power_state))
    else $error("power flags changed on host write");

  a_read_flags: assert property (@(posedge clock) disable iff (!reset_n)
    reg_rd && reg_addr == POWER_STATE_FLAGS_OFS |=> reg_rvalid && reg_rdata == $past(power_state))
    else $error("power flag readback wrong");
endmodule : shrw_register_window
`default_nettype wire

// ### tb/shrw_host_model.sv
// host controller model driving the register strobe port
`timescale 1ns/1ps
`default_nettype none
module shrw_host_model (
  input wire logic clock,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // parameters are reached only by fetch, store and apply-address commands, never from here
  // reserved parameters are never stored by this host
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    // released lines flip so stale values cannot pass
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    // answer stands one cycle only; missing answer reads unknown
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
  endtask : rd
endmodule : shrw_host_model
`default_nettype wire

// ### tb/test_sensor_host_register_window.sv
// self-checking bench for the sensor host register window
`timescale 1ns/1ps
`default_nettype none
module test_sensor_host_register_window;
  import shrw_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, cmd_data, aux_value;
  logic [7:0] active_bus_address, power_state;
  logic reg_wr, reg_rd, reg_rvalid, cmd_valid, aux_load, channel_list_ready;
  logic seq_wake = 1'b0;
  logic seq_suspend = 1'b0;
  logic seq_sleep = 1'b0;
  shrw_cmd_t cmd_code = SHRW_CMD_NONE;
  logic [PARAM_AW-1:0] cmd_offset = 5'h00;
  int fail_count = 0;
  int tests_run = 0;
  initial cmd_valid = 1'b0;
  initial cmd_data = 8'h00;
  initial aux_load = 1'b0;
  initial aux_value = 8'h00;
  always #25 clock = ~clock;

  shrw_register_window shrw_register_window_i (
    .clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_offset(cmd_offset),
    .cmd_data(cmd_data), .aux_load(aux_load), .aux_value(aux_value),
    .seq_wake(seq_wake), .seq_suspend(seq_suspend), .seq_sleep(seq_sleep),
    .active_bus_address(active_bus_address), .channel_list_ready(channel_list_ready),
    .power_state(power_state)
  );
  shrw_host_model host_i (
    .clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
  );

  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
    tests_run++;
    if (seen !== want) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
    end
  endtask : check
  task automatic rchk(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] d;
    host_i.rd(a, d);
    check(d, want, $sformatf("read %h", a));
  endtask : rchk
  task automatic cmd(input shrw_cmd_t c, input logic [4:0] o, input logic [7:0] d);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_offset = o;
    cmd_data = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_code = SHRW_CMD_NONE;
    cmd_offset = ~o;
    cmd_data = ~d;
  endtask : cmd

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rchk(AUX_RESULT_HIGH_OFS, 8'h00);
    rchk(PARAM_READBACK_OFS, 8'h00);
    rchk(POWER_STATE_FLAGS_OFS, 8'h04);
    for (int i = 0; i < 4; i++) begin
      rchk(ANALOG_KEY_OFS + i[7:0], 8'h00);
    end
    rchk(8'h2f, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_aux;
    host_i.wr(AUX_RESULT_HIGH_OFS, 8'ha5);
    rchk(AUX_RESULT_HIGH_OFS, 8'ha5);
    @(negedge clock);
    aux_load = 1'b1;
    aux_value = 8'h3c;
    @(negedge clock);
    aux_load = 1'b0;
    aux_value = 8'hc3;
    // fetched before the next load would overwrite it
    rchk(AUX_RESULT_HIGH_OFS, 8'h3c);
    $display("test aux done");
  endtask : t_aux
  task automatic t_power;
    logic [2:0] req [4] = '{3'b010, 3'b001, 3'b011, 3'b111};
    logic [7:0] want [4] = '{8'h02, 8'h01, 8'h02, 8'h04};
    for (int i = 0; i < 4; i++) begin
      @(negedge clock);
      {seq_wake, seq_suspend, seq_sleep} = req[i];
      @(negedge clock);
      {seq_wake, seq_suspend, seq_sleep} = 3'b000;
      check(power_state, want[i], "power port");
      rchk(POWER_STATE_FLAGS_OFS, want[i]);
    end
    host_i.wr(POWER_STATE_FLAGS_OFS, 8'hff);
    rchk(POWER_STATE_FLAGS_OFS, 8'h04);
    $display("test power done");
  endtask : t_power
  task automatic t_params;
    logic [4:0] ofs [5] = '{5'h0d, 5'h13, 5'h14, 5'h15, 5'h00};
    logic [7:0] want [5] = '{8'h02, 8'h40, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++) begin
      cmd(SHRW_CMD_FETCH, ofs[i], 8'h77);
      rchk(PARAM_READBACK_OFS, want[i]);
    end
    // a bus write at the parameter's number must not reach the memory
    host_i.wr(8'h0d, 8'hff);
    cmd(SHRW_CMD_FETCH, 5'h0d, 8'h00);
    rchk(PARAM_READBACK_OFS, 8'h02);
    cmd(SHRW_CMD_STORE, PROX_ADC_COUNTER_PARAM, 8'ha0);
    rchk(PARAM_READBACK_OFS, 8'ha0);
    cmd(SHRW_CMD_NONE, 5'h0d, 8'h55);
    rchk(PARAM_READBACK_OFS, 8'ha0);
    host_i.wr(PARAM_READBACK_OFS, 8'h00);
    cmd(SHRW_CMD_FETCH, PROX_ADC_COUNTER_PARAM, 8'h00);
    rchk(PARAM_READBACK_OFS, 8'ha0);
    $display("test params done");
  endtask : t_params
  task automatic t_addr;
    check({7'h00, channel_list_ready}, 8'h00, "list empty");
    cmd(SHRW_CMD_STORE, CHANNEL_ENABLE_LIST_PARAM, 8'h41);
    check({7'h00, channel_list_ready}, 8'h01, "list set");
    cmd(SHRW_CMD_STORE, BUS_ADDRESS_PARAM, 8'h5b);
    check(active_bus_address, 8'h00, "addr before apply");
    cmd(SHRW_CMD_APPLY_ADDR, 5'h1f, 8'h00);
    check(active_bus_address, 8'h5b, "addr after apply");
    $display("test address done");
  endtask : t_addr

  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    close_out();
  end
  initial begin
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    t_reset();
    t_aux();
    t_power();
    t_params();
    t_addr();
    close_out();
  end
endmodule : test_sensor_host_register_window
`default_nettype wire
